// file: verilog/bioz_cfg_pkg.sv
// constants, field layout and types for the bioimpedance tx/rx configuration bank
// Behaviour
// - stimulus code 0x0 runs current drive into body through selected electrodes
// - code 0x1 drives sine voltage on first electrode, fourth held at tx mid-rail
// - code 0x2 switches first and fourth electrodes alternately between supply and ground
// - code 0x3 holds transmit in low-power reset, electrodes at tx mid-rail
// - fast-start active closes resistor switches tying both rx inputs to rx mid-rail
// - fast-start enable at 0 never activates fast-start, whatever hold says
// - enable 1, hold 0: fast-start runs about 200ms after a channel enables
// - enable and hold both 1 keep fast-start on until hold is written to 0
// - highpass codes 0-6 corners, 8-E resistances with caps shorted, 7/F bypass
// - amplifier power bit 0 selects low-noise high power, 1 selects low power
// - demod bypass 1 stops demodulation clock, 0 lets it run
// - gain codes give totals 1,2,5,10; first code amp 1, others amp 2
// - transmit standby disables rx chain unless rx-on-in-standby bit is 1
package bioz_cfg_pkg;

  // ----------------------------------------------------------------
  // bus and register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned IDX_W  = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W  = 8;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_MODE_CTRL  = 8'h20;
  localparam logic [IDX_W-1:0] IDX_STATUS     = 8'h21;
  localparam logic [IDX_W-1:0] IDX_FAST_START = 8'h23;
  localparam logic [IDX_W-1:0] IDX_FILT_GAIN  = 8'h24;
  localparam logic [IDX_W-1:0] IDX_TX_DRV_AMP = 8'h25;

  // writable bit masks and reset values
  localparam logic [REG_W-1:0] MASK_MODE_CTRL  = 8'h1F;
  localparam logic [REG_W-1:0] MASK_FAST_START = 8'h03;
  localparam logic [REG_W-1:0] MASK_FILT_GAIN  = 8'hFF;
  localparam logic [REG_W-1:0] MASK_TX_DRV_AMP = 8'hFF;
  localparam logic [REG_W-1:0] RST_MODE_CTRL   = 8'h03;
  localparam logic [REG_W-1:0] RST_FAST_START  = 8'h00;
  localparam logic [REG_W-1:0] RST_FILT_GAIN   = 8'h00;
  localparam logic [REG_W-1:0] RST_TX_DRV_AMP  = 8'h80;

  // field positions
  localparam int unsigned STIM_LSB     = 0;
  localparam int unsigned IEN_BIT      = 2;
  localparam int unsigned QEN_BIT      = 3;
  localparam int unsigned STBYON_BIT   = 4;
  localparam int unsigned FS_EN_BIT    = 0;
  localparam int unsigned FS_HOLD_BIT  = 1;
  localparam int unsigned GAIN_LSB     = 0;
  localparam int unsigned DM_BIT       = 2;
  localparam int unsigned INA_BIT      = 3;
  localparam int unsigned HPF_LSB      = 4;
  localparam int unsigned ST_FAST_BIT  = 0;
  localparam int unsigned ST_RXON_BIT  = 1;
  localparam int unsigned ST_STIM_LSB  = 2;

  // field codes
  localparam logic [1:0] STIM_CURRENT = 2'h0;
  localparam logic [1:0] STIM_VOLTAGE = 2'h1;
  localparam logic [1:0] STIM_HBRIDGE = 2'h2;
  localparam logic [1:0] STIM_STANDBY = 2'h3;
  localparam logic [3:0] HPF_BYPASS_A = 4'h7;
  localparam logic [3:0] HPF_BYPASS_B = 4'hF;
  localparam logic [1:0] GAIN_UNITY   = 2'h0;
  localparam logic [1:0] PGA_X1       = 2'h0;
  localparam logic [1:0] PGA_X2P5     = 2'h1;
  localparam logic [1:0] PGA_X5       = 2'h2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned FAST_START_MS  = 200;
  localparam int unsigned FAST_START_CYC = FAST_START_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned FS_CNT_W       = 25;
  localparam int unsigned HB_HALF_CYC    = 16;
  localparam int unsigned HB_CNT_W       = 16;

  // transmit stimulus state, one-hot
  typedef enum logic [3:0] {
    TX_CURRENT = 4'b0001,
    TX_VOLTAGE = 4'b0010,
    TX_HBRIDGE = 4'b0100,
    TX_STANDBY = 4'b1000
  } tx_mode_t;

endpackage : bioz_cfg_pkg

// file: verilog/bioz_tx_rx_config_regs.sv
// configuration bank and control decode for the bioimpedance transmit and receive paths
`timescale 1ns/1ps
`default_nettype none
module bioz_tx_rx_config_regs #(
  parameter int unsigned FAST_START_CYCLES = bioz_cfg_pkg::FAST_START_CYC,
  parameter int unsigned HBRIDGE_HALF_CYC  = bioz_cfg_pkg::HB_HALF_CYC
) (
  // clock and reset
  input  wire logic                              core_clk,
  input  wire logic                              rst_n,
  // axi4-lite write address and data
  input  wire logic [bioz_cfg_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                              s_axi_awvalid,
  output logic                                   s_axi_awready,
  input  wire logic [bioz_cfg_pkg::DATA_W-1:0]   s_axi_wdata,
  input  wire logic [3:0]                        s_axi_wstrb,
  input  wire logic                              s_axi_wvalid,
  output logic                                   s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                             s_axi_bresp,
  output logic                                   s_axi_bvalid,
  input  wire logic                              s_axi_bready,
  // axi4-lite read
  input  wire logic [bioz_cfg_pkg::ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                              s_axi_arvalid,
  output logic                                   s_axi_arready,
  output logic [bioz_cfg_pkg::DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]                             s_axi_rresp,
  output logic                                   s_axi_rvalid,
  input  wire logic                              s_axi_rready,
  // transmit controls
  output logic                                   tx_current_drive_en,
  output logic                                   tx_voltage_drive_en,
  output logic                                   tx_hbridge_en,
  output logic                                   tx_reset_hold,
  output logic                                   drive_electrode_first_mid,
  output logic                                   drive_electrode_fourth_mid,
  output logic                                   drive_electrode_first_high,
  output logic                                   drive_electrode_fourth_high,
  // receive controls
  output logic                                   inphase_chan_on,
  output logic                                   quad_chan_on,
  output logic                                   rx_chain_en,
  output logic                                   fast_start_switch_en,
  output logic                                   hpf_corner_en,
  output logic                                   hpf_res_en,
  output logic                                   hpf_bypass,
  output logic [2:0]                             hpf_step_sel,
  output logic                                   inamp_low_power,
  output logic                                   demod_clk_en,
  output logic                                   input_amplifier_gain2,
  output logic [1:0]                             second_stage_amp_sel,
  // raw transmit amplifier settings, decoded elsewhere
  output logic [7:0]                             tx_drive_amp_cfg
);
  import bioz_cfg_pkg::*;

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [REG_W-1:0]  mode_ctrl_q;
  logic [REG_W-1:0]  fast_start_q;
  logic [REG_W-1:0]  filt_gain_q;
  logic [REG_W-1:0]  tx_drv_amp_q;
  logic [REG_W-1:0]  status_w;
  // write channel holding
  logic              aw_full_q;
  logic              w_full_q;
  logic [IDX_W-1:0]  wr_idx_q;
  logic [REG_W-1:0]  wr_data_q;
  logic              wr_lane_q;
  logic              do_write;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              wr_hit;
  // read channel
  logic              rvalid_q;
  logic [DATA_W-1:0] rdata_q;
  logic [1:0]        rresp_q;
  logic [IDX_W-1:0]  rd_idx;
  logic [REG_W-1:0]  rd_val;
  logic              rd_hit;

  // ----------------------------------------------------------------
  // axi write path
  // ----------------------------------------------------------------
  // address and data are caught independently, so either may come first
  assign s_axi_awready = ~aw_full_q & ~bvalid_q;
  assign s_axi_wready  = ~w_full_q & ~bvalid_q;
  assign do_write      = aw_full_q & w_full_q & ~bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  always_comb begin
    unique case (wr_idx_q)
      IDX_MODE_CTRL, IDX_STATUS, IDX_FAST_START, IDX_FILT_GAIN, IDX_TX_DRV_AMP: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end
  // address capture
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_full_q <= 1'b0;
      wr_idx_q  <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_q <= 1'b1;
      wr_idx_q  <= s_axi_awaddr[IDX_W+1:2];
    end else if (do_write) begin
      aw_full_q <= 1'b0;
    end
  end
  // data capture; only lane 0 carries register bits
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      w_full_q  <= 1'b0;
      wr_data_q <= '0;
      wr_lane_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_q  <= 1'b1;
      wr_data_q <= s_axi_wdata[REG_W-1:0];
      wr_lane_q <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_full_q <= 1'b0;
    end
  end
  // response; unmapped addresses answer slverr
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // unused bits are masked off on write so they always read zero
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_ctrl_q <= RST_MODE_CTRL;
    end else if (do_write && wr_lane_q && wr_idx_q == IDX_MODE_CTRL) begin
      mode_ctrl_q <= wr_data_q & MASK_MODE_CTRL;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fast_start_q <= RST_FAST_START;
    end else if (do_write && wr_lane_q && wr_idx_q == IDX_FAST_START) begin
      fast_start_q <= wr_data_q & MASK_FAST_START;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      filt_gain_q <= RST_FILT_GAIN;
    end else if (do_write && wr_lane_q && wr_idx_q == IDX_FILT_GAIN) begin
      filt_gain_q <= wr_data_q & MASK_FILT_GAIN;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_drv_amp_q <= RST_TX_DRV_AMP;
    end else if (do_write && wr_lane_q && wr_idx_q == IDX_TX_DRV_AMP) begin
      tx_drv_amp_q <= wr_data_q & MASK_TX_DRV_AMP;
    end
  end

  // ----------------------------------------------------------------
  // axi read path
  // ----------------------------------------------------------------
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign rd_idx        = s_axi_araddr[IDX_W+1:2];
  always_comb begin
    rd_hit = 1'b1;
    unique case (rd_idx)
      IDX_MODE_CTRL:  rd_val = mode_ctrl_q;
      IDX_STATUS:     rd_val = status_w;
      IDX_FAST_START: rd_val = fast_start_q;
      IDX_FILT_GAIN:  rd_val = filt_gain_q;
      IDX_TX_DRV_AMP: rd_val = tx_drv_amp_q;
      default: begin
        rd_val = '0;
        rd_hit = 1'b0;
      end
    endcase
  end
  // upper 24 bits always read zero
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= {{(DATA_W-REG_W){1'b0}}, rd_val};
      rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // fast-start sequencer
  // ----------------------------------------------------------------
  logic                fs_en;
  logic                fs_hold;
  logic                chan_any;
  logic                chan_any_q;
  logic                chan_rise;
  logic [FS_CNT_W-1:0] fs_cnt_q;
  logic                fs_active;
  assign fs_en     = fast_start_q[FS_EN_BIT];
  assign fs_hold   = fast_start_q[FS_HOLD_BIT];
  assign chan_any  = mode_ctrl_q[IEN_BIT] | mode_ctrl_q[QEN_BIT];
  assign chan_rise = chan_any & ~chan_any_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_any_q <= 1'b0;
    end else begin
      chan_any_q <= chan_any;
    end
  end
  // timer is cleared whenever automatic mode does not apply, so a later
  // hold release ends fast-start at once instead of resuming a stale count
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fs_cnt_q <= '0;
    end else if (!fs_en || fs_hold) begin
      fs_cnt_q <= '0;
    end else if (chan_rise) begin
      fs_cnt_q <= FS_CNT_W'(FAST_START_CYCLES);
    end else if (fs_cnt_q != '0) begin
      fs_cnt_q <= fs_cnt_q - FS_CNT_W'(1);
    end
  end
  // enable gates both hold and timer
  assign fs_active = fs_en & (fs_hold | (fs_cnt_q != '0));

  // ----------------------------------------------------------------
  // transmit mode and h-bridge phase
  // ----------------------------------------------------------------
  tx_mode_t            tx_mode;
  logic [HB_CNT_W-1:0] hb_cnt_q;
  logic                hb_phase_q;
  always_comb begin
    unique case (mode_ctrl_q[STIM_LSB +: 2])
      STIM_CURRENT: tx_mode = TX_CURRENT;
      STIM_VOLTAGE: tx_mode = TX_VOLTAGE;
      STIM_HBRIDGE: tx_mode = TX_HBRIDGE;
      STIM_STANDBY: tx_mode = TX_STANDBY;
    endcase
  end
  // phase divider only runs in h-bridge mode so it starts from a known side
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hb_cnt_q   <= '0;
      hb_phase_q <= 1'b0;
    end else if (tx_mode != TX_HBRIDGE) begin
      hb_cnt_q   <= '0;
      hb_phase_q <= 1'b0;
    end else if (hb_cnt_q == HB_CNT_W'(HBRIDGE_HALF_CYC - 1)) begin
      hb_cnt_q   <= '0;
      hb_phase_q <= ~hb_phase_q;
    end else begin
      hb_cnt_q <= hb_cnt_q + HB_CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // registered control outputs
  // ----------------------------------------------------------------
  logic       rx_on;
  logic [3:0] hpf_code;
  logic [1:0] gain_code;
  assign rx_on     = (tx_mode != TX_STANDBY) | mode_ctrl_q[STBYON_BIT];
  assign hpf_code  = filt_gain_q[HPF_LSB +: 4];
  assign gain_code = filt_gain_q[GAIN_LSB +: 2];
  assign status_w  = {3'b000, mode_ctrl_q[STIM_LSB +: 2], 1'b0, rx_on, fs_active};
  // transmit switch decode
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_current_drive_en         <= 1'b0;
      tx_voltage_drive_en         <= 1'b0;
      tx_hbridge_en               <= 1'b0;
      tx_reset_hold               <= 1'b1;
      drive_electrode_first_mid   <= 1'b1;
      drive_electrode_fourth_mid  <= 1'b1;
      drive_electrode_first_high  <= 1'b0;
      drive_electrode_fourth_high <= 1'b0;
    end else begin
      tx_current_drive_en         <= tx_mode == TX_CURRENT;
      tx_voltage_drive_en         <= tx_mode == TX_VOLTAGE;
      tx_hbridge_en               <= tx_mode == TX_HBRIDGE;
      tx_reset_hold               <= tx_mode == TX_STANDBY;
      drive_electrode_first_mid   <= tx_mode == TX_STANDBY;
      drive_electrode_fourth_mid  <= tx_mode == TX_VOLTAGE || tx_mode == TX_STANDBY;
      drive_electrode_first_high  <= tx_mode == TX_HBRIDGE && !hb_phase_q;
      drive_electrode_fourth_high <= tx_mode == TX_HBRIDGE && hb_phase_q;
    end
  end
  // receive decode
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      inphase_chan_on       <= 1'b0;
      quad_chan_on          <= 1'b0;
      rx_chain_en           <= 1'b0;
      fast_start_switch_en  <= 1'b0;
      hpf_corner_en         <= 1'b1;
      hpf_res_en            <= 1'b0;
      hpf_bypass            <= 1'b0;
      hpf_step_sel          <= '0;
      inamp_low_power       <= 1'b0;
      demod_clk_en          <= 1'b0;
      input_amplifier_gain2 <= 1'b0;
      second_stage_amp_sel  <= PGA_X1;
      tx_drive_amp_cfg      <= RST_TX_DRV_AMP;
    end else begin
      inphase_chan_on       <= mode_ctrl_q[IEN_BIT] & rx_on;
      quad_chan_on          <= mode_ctrl_q[QEN_BIT] & rx_on;
      rx_chain_en           <= rx_on;
      fast_start_switch_en  <= fs_active;
      hpf_bypass            <= hpf_code == HPF_BYPASS_A || hpf_code == HPF_BYPASS_B;
      hpf_corner_en         <= !hpf_code[3] && hpf_code != HPF_BYPASS_A;
      hpf_res_en            <= hpf_code[3] && hpf_code != HPF_BYPASS_B;
      hpf_step_sel          <= hpf_code[2:0];
      inamp_low_power       <= filt_gain_q[INA_BIT];
      demod_clk_en          <= !filt_gain_q[DM_BIT] && rx_on;
      input_amplifier_gain2 <= gain_code != GAIN_UNITY;
      // codes 1..3 map to second-stage 1, 2.5, 5
      second_stage_amp_sel  <= (gain_code == GAIN_UNITY) ? PGA_X1
                                                         : gain_code - 2'h1;
      tx_drive_amp_cfg      <= tx_drv_amp_q;
    end
  end

endmodule : bioz_tx_rx_config_regs
`default_nettype wire

// file: test/bioz_tx_rx_config_regs_chk.sv
// assertion checker for the bioimpedance configuration bank outputs
`timescale 1ns/1ps
`default_nettype none
module bioz_tx_rx_config_regs_chk (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       rst_n,
  // transmit controls
  input wire logic       tx_current_drive_en,
  input wire logic       tx_voltage_drive_en,
  input wire logic       tx_hbridge_en,
  input wire logic       tx_reset_hold,
  input wire logic       drive_electrode_first_mid,
  input wire logic       drive_electrode_fourth_mid,
  input wire logic       drive_electrode_first_high,
  input wire logic       drive_electrode_fourth_high,
  // receive controls
  input wire logic       inphase_chan_on,
  input wire logic       quad_chan_on,
  input wire logic       rx_chain_en,
  input wire logic       demod_clk_en,
  input wire logic       hpf_corner_en,
  input wire logic       hpf_res_en,
  input wire logic       hpf_bypass,
  input wire logic       input_amplifier_gain2,
  input wire logic [1:0] second_stage_amp_sel
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ------------------------------------------------------------
  // transmit decode
  // ------------------------------------------------------------
  a_stim_onehot: assert property ($onehot({tx_current_drive_en,
    tx_voltage_drive_en, tx_hbridge_en, tx_reset_hold})) else $error("stimulus not one-hot");
  a_standby_mid: assert property (tx_reset_hold |-> drive_electrode_first_mid
    && drive_electrode_fourth_mid && !drive_electrode_first_high) else $error("standby not mid");
  a_voltage_mid: assert property (tx_voltage_drive_en |-> drive_electrode_fourth_mid
    && !drive_electrode_first_mid) else $error("voltage drive electrodes wrong");
  a_bridge_excl: assert property (!(drive_electrode_first_high
    && drive_electrode_fourth_high)) else $error("both bridge legs high");
  // legs and mode flag are registered together
  a_bridge_only: assert property (!tx_hbridge_en |-> !drive_electrode_first_high
    && !drive_electrode_fourth_high) else $error("bridge outside mode");
  // ------------------------------------------------------------
  // receive decode
  // ------------------------------------------------------------
  a_hpf_onehot: assert property ($onehot({hpf_corner_en, hpf_res_en, hpf_bypass}))
    else $error("highpass decode not one-hot");
  a_rx_gating: assert property ((inphase_chan_on || quad_chan_on || demod_clk_en) |->
    rx_chain_en) else $error("rx part on while chain off");
  a_gain_map: assert property (second_stage_amp_sel != 2'h0 |-> input_amplifier_gain2
    && second_stage_amp_sel != 2'h3) else $error("gain stage mapping wrong");
endmodule : bioz_tx_rx_config_regs_chk
bind bioz_tx_rx_config_regs bioz_tx_rx_config_regs_chk bioz_tx_rx_config_regs_chk_inst (
  .core_clk, .rst_n, .tx_current_drive_en, .tx_voltage_drive_en, .tx_hbridge_en,
  .tx_reset_hold, .drive_electrode_first_mid, .drive_electrode_fourth_mid,
  .drive_electrode_first_high, .drive_electrode_fourth_high, .inphase_chan_on,
  .quad_chan_on, .rx_chain_en, .demod_clk_en, .hpf_corner_en, .hpf_res_en, .hpf_bypass,
  .input_amplifier_gain2, .second_stage_amp_sel);
`default_nettype wire

// file: test/test_bioz_tx_rx_config_regs.sv
// self-checking bench for the bioimpedance configuration bank over axi4-lite
`timescale 1ns/1ps
`default_nettype none
module test_bioz_tx_rx_config_regs;
  import bioz_cfg_pkg::*;
  // short counts keep the run brief; expectations follow them
  localparam int FS = 20;
  localparam int HB = 4;
  logic core_clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, second_stage_amp_sel, rs, es;
  logic tx_current_drive_en, tx_voltage_drive_en, tx_hbridge_en, tx_reset_hold;
  logic drive_electrode_first_mid, drive_electrode_fourth_mid;
  logic drive_electrode_first_high, drive_electrode_fourth_high;
  logic inphase_chan_on, quad_chan_on, rx_chain_en, fast_start_switch_en, hpf_corner_en;
  logic hpf_res_en, hpf_bypass, inamp_low_power, demod_clk_en, input_amplifier_gain2;
  logic [2:0] hpf_step_sel, eh;
  logic [7:0] tx_drive_amp_cfg, v;
  logic [31:0] rd;
  int err_total = 0, checked = 0, cycles = 0, fs_cnt = 0, fs_base;
  bioz_tx_rx_config_regs #(.FAST_START_CYCLES(FS), .HBRIDGE_HALF_CYC(HB))
    bioz_tx_rx_config_regs_inst (
    .core_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .tx_current_drive_en, .tx_voltage_drive_en, .tx_hbridge_en, .tx_reset_hold,
    .drive_electrode_first_mid, .drive_electrode_fourth_mid, .drive_electrode_first_high,
    .drive_electrode_fourth_high, .inphase_chan_on, .quad_chan_on, .rx_chain_en,
    .fast_start_switch_en, .hpf_corner_en, .hpf_res_en, .hpf_bypass, .hpf_step_sel,
    .inamp_low_power, .demod_clk_en, .input_amplifier_gain2, .second_stage_amp_sel,
    .tx_drive_amp_cfg);
  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;
  // hang guard and fast-start on-time meter
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (fast_start_switch_en === 1'b1) fs_cnt <= fs_cnt + 1;
    if (cycles == 20000) begin
      err_total++;
      print_verdict();
    end
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic print_verdict();
    if (err_total == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // both halves offered together, each released when taken
  task automatic wr(input logic [7:0] idx, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= {2'h0, idx, 2'h0};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    @(posedge core_clk);
    while (s_axi_awvalid || s_axi_wvalid || s_axi_bready) begin
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bready && s_axi_bvalid === 1'b1) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
      @(posedge core_clk);
    end
  endtask : wr
  task automatic rdr(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= {2'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(posedge core_clk);
    while (s_axi_arvalid || s_axi_rready) begin
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rready && s_axi_rvalid === 1'b1) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
      @(posedge core_clk);
    end
  endtask : rdr
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rdr(IDX_MODE_CTRL, rd, rs); chk("mode reset", 32'h03, rd); chk("rresp", RESP_OKAY, rs);
    rdr(IDX_FAST_START, rd, rs); chk("fast reset", 32'h00, rd);
    rdr(IDX_FILT_GAIN, rd, rs); chk("filt reset", 32'h00, rd);
    rdr(IDX_TX_DRV_AMP, rd, rs); chk("amp reset", 32'h80, rd);
    wr(IDX_FAST_START, 32'hFFFF_FFFC, rs); chk("fast bresp", RESP_OKAY, rs);
    rdr(IDX_FAST_START, rd, rs); chk("unused", 0, rd);
    wr(IDX_TX_DRV_AMP, 32'hFFFF_FF3C, rs); rdr(IDX_TX_DRV_AMP, rd, rs);
    chk("amp rd", 32'h3C, rd); chk("amp out", 32'h3C, tx_drive_amp_cfg);
    wr(8'h00, 32'h55, rs); chk("bad bresp", RESP_SLVERR, rs);
    rdr(8'h00, rd, rs); chk("bad rresp", RESP_SLVERR, rs); chk("bad data", 0, rd);
    for (int c = 0; c < 4; c++) begin
      wr(IDX_MODE_CTRL, 32'h04 | c, rs);
      repeat (2 * HB) @(posedge core_clk);
      chk("stim", 1 << c, {tx_reset_hold, tx_hbridge_en,
        tx_voltage_drive_en, tx_current_drive_en});
      chk("mids", {c == 3, c == 1 || c == 3},
        {drive_electrode_first_mid, drive_electrode_fourth_mid});
      chk("bridge", c == 2, drive_electrode_first_high ^ drive_electrode_fourth_high);
      chk("rx gate", {3{c != 3}}, {rx_chain_en, inphase_chan_on, demod_clk_en});
    end
    wr(IDX_MODE_CTRL, 32'h1B, rs);
    chk("stby on", 3'b110, {rx_chain_en, quad_chan_on, inphase_chan_on});
    wr(IDX_MODE_CTRL, 32'h00, rs);
    for (int c = 0; c < 16; c++) begin
      v = 8'(c * 17);
      wr(IDX_FILT_GAIN, {24'hFFFFFF, v}, rs); rdr(IDX_FILT_GAIN, rd, rs);
      chk("filt rd", v, rd);
      eh = (v[6:4] == 3'h7) ? 3'b001 : (v[7] ? 3'b010 : 3'b100);
      chk("hpf", {eh, v[6:4]}, {hpf_corner_en, hpf_res_en, hpf_bypass, hpf_step_sel});
      chk("amp mode", {v[3], !v[2]}, {inamp_low_power, demod_clk_en});
      es = (v[1:0] == 2'h3) ? 2'h2 : ((v[1:0] == 2'h2) ? 2'h1 : 2'h0);
      chk("gain", {v[1:0] != 2'h0, es}, {input_amplifier_gain2, second_stage_amp_sel});
    end
    wr(IDX_FAST_START, 32'h01, rs); fs_base = fs_cnt; wr(IDX_MODE_CTRL, 32'h04, rs);
    repeat (3 * FS) @(posedge core_clk); chk("fast auto", FS, fs_cnt - fs_base);
    wr(IDX_MODE_CTRL, 32'h00, rs); fs_base = fs_cnt; wr(IDX_MODE_CTRL, 32'h08, rs);
    repeat (3 * FS) @(posedge core_clk); chk("fast again", FS, fs_cnt - fs_base);
    wr(IDX_FAST_START, 32'h02, rs); wr(IDX_MODE_CTRL, 32'h00, rs); fs_base = fs_cnt;
    wr(IDX_MODE_CTRL, 32'h04, rs);
    repeat (3 * FS) @(posedge core_clk); chk("fast off", 0, fs_cnt - fs_base);
    wr(IDX_FAST_START, 32'h03, rs); repeat (3 * FS) @(posedge core_clk);
    rdr(IDX_STATUS, rd, rs); chk("fast stat", 1'b1, rd[0]); fs_base = fs_cnt;
    repeat (40) @(posedge core_clk); chk("fast hold", 40, fs_cnt - fs_base);
    wr(IDX_FAST_START, 32'h01, rs); fs_base = fs_cnt;
    repeat (40) @(posedge core_clk); chk("hold end", 0, fs_cnt - fs_base);
    print_verdict();
  end
endmodule : test_bioz_tx_rx_config_regs
`default_nettype wire
